// ===== gpp_pkg.sv
// Purpose: Shared constants for the eight-pin general-purpose port
// Assumes: One port instance per package use; widths fixed
// Notes: Register offsets are word-aligned byte offsets in the port space
package gpp_pkg;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int PINS = 8;
	localparam int ADDR_W = 12;
	localparam int MASK_LO = 2;
	localparam int MASK_HI = 9;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_DATA_TOP = 12'h3fc;
	localparam logic [11:0] OFS_DIR = 12'h400;
	localparam logic [11:0] OFS_IS = 12'h404;
	localparam logic [11:0] OFS_IBE = 12'h408;
	localparam logic [11:0] OFS_IEV = 12'h40c;
	localparam logic [11:0] OFS_IM = 12'h410;
	localparam logic [11:0] OFS_RIS = 12'h414;
	localparam logic [11:0] OFS_MIS = 12'h418;
	localparam logic [11:0] OFS_ICR = 12'h41c;
	localparam logic [11:0] OFS_AFSEL = 12'h420;
	localparam logic [11:0] OFS_DR2 = 12'h500;
	localparam logic [11:0] OFS_DR4 = 12'h504;
	localparam logic [11:0] OFS_DR8 = 12'h508;
	localparam logic [11:0] OFS_ODR = 12'h50c;
	localparam logic [11:0] OFS_PUR = 12'h510;
	localparam logic [11:0] OFS_PDR = 12'h514;
	localparam logic [11:0] OFS_SLR = 12'h518;
	localparam logic [11:0] OFS_DEN = 12'h51c;
	localparam logic [11:0] OFS_LOCK = 12'h520;
	localparam logic [11:0] OFS_CR = 12'h524;
	localparam logic [11:0] OFS_PID0 = 12'hfd0;
	localparam logic [11:0] OFS_CID3 = 12'hffc;
	// ------------------------------------------------------------
	// Reset values and keys
	// ------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DR2 = 8'hff;
	localparam logic [7:0] RST_CR = 8'hff;
	localparam logic [31:0] LOCK_KEY = 32'h1acce551;
	// Arbitrary identity byte, neutral value
	localparam logic [7:0] ID_BYTE = 8'h5a;
endpackage : gpp_pkg

// ===== gpp_cfg_if.sv
// Purpose: Carries per-pin configuration between port modules
// Assumes: Single clock domain
// Notes: Top drives config and pins, detector consumes them and drives raw status back
`timescale 1ns/100ps
interface gpp_cfg_if;
	logic [7:0] sense;
	logic [7:0] both;
	logic [7:0] event_hi;
	logic [7:0] mask;
	logic [7:0] clr;
	logic [7:0] pin_in;
	logic [7:0] raw;
	modport ctl (output sense, output both, output event_hi, output mask,
		output clr, output pin_in, input raw);
	modport det (input sense, input both, input event_hi, input mask,
		input clr, input pin_in, output raw);
endinterface : gpp_cfg_if

// ===== gpp_irq_det.sv
// Purpose: Per-pin interrupt detection with sticky edge status
// Assumes: Pin inputs synchronous to clk
// Notes: Level conditions follow the pin; edge conditions latch
`timescale 1ns/100ps
module gpp_irq_det (
	input wire logic clk,
	input wire logic rst,
	gpp_cfg_if.det cfg
);
	logic [7:0] prev_q;
	logic [7:0] prev_d;
	logic [7:0] edge_q;
	logic [7:0] edge_d;
	logic [7:0] hit;

	// ------------------------------------------------------------
	// Detection per pin
	// ------------------------------------------------------------
	always_comb
	begin
		prev_d = cfg.pin_in;
		for (int i = 0; i < gpp_pkg::PINS; i++)
		begin
			if (cfg.both[i])
				hit[i] = prev_q[i] ^ cfg.pin_in[i];
			else if (cfg.event_hi[i])
				hit[i] = ~prev_q[i] & cfg.pin_in[i];
			else
				hit[i] = prev_q[i] & ~cfg.pin_in[i];
			// Set beats clear in the same cycle
			edge_d[i] = (edge_q[i] & ~cfg.clr[i]) | hit[i];
			if (cfg.sense[i])
				cfg.raw[i] = ~(cfg.pin_in[i] ^ cfg.event_hi[i]);
			else
				cfg.raw[i] = edge_q[i];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			prev_q <= gpp_pkg::RST_ZERO;
			edge_q <= gpp_pkg::RST_ZERO;
		end
		else
		begin
			prev_q <= prev_d;
			edge_q <= edge_d;
		end
	end
endmodule : gpp_irq_det

// ===== gpp_pad_mux.sv
// Purpose: Selects per-pin driver between software and peripheral
// Assumes: Open drain drives low only
// Notes: Purely combinational
`timescale 1ns/100ps
module gpp_pad_mux (
	input wire logic [7:0] alt_sel,
	input wire logic [7:0] dir,
	input wire logic [7:0] data,
	input wire logic [7:0] odr,
	input wire logic [7:0] periph_out,
	input wire logic [7:0] periph_oe,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe
);
	logic [7:0] val;
	logic [7:0] en;

	// ------------------------------------------------------------
	// Per-pin selection
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_pin
			assign val[g] = alt_sel[g] ? periph_out[g] : data[g];
			assign en[g] = alt_sel[g] ? periph_oe[g] : dir[g];
			// Open drain only ever pulls low
			assign pad_out[g] = odr[g] ? 1'b0 : val[g];
			assign pad_oe[g] = odr[g] ? (en[g] & ~val[g]) : en[g];
		end
	endgenerate
endmodule : gpp_pad_mux

// ===== gpp_port.sv
// Purpose: Eight-pin general-purpose port with masked data access
// Assumes: Simple single-cycle register strobes, synchronous pins
// Notes: Debug pin set chosen by parameter; identical per instance
// Operation
// - Input pins: data bit samples pin level
// - Output pins: data bit drives pin
// - Address bits 9:2 mask data bits
// - Data register aliases over 256 words
// - Masked write changes only enabled bits
// - Masked read returns zero for others
// - One combined port interrupt output
// - Edge events stay pending until cleared
// - Rising, falling, both, high, low detection
// - Mask bit gates pin onto interrupt
// - Raw and masked status both readable
// - Writing one clears pending bit
// - Unmasked trigger pin drives converter trigger
// - Alternate select hands pin to peripheral
// - Debug alternate bits need unlock, commit
// - Ordinary pins reset tri-stated
// - Debug pins reset to debug function
// - Any reset restores default configuration
// - Pad bits: drive, drain, pulls, slew, enable
// - Identical instances with identity registers
`timescale 1ns/100ps
module gpp_port #(
	parameter logic [7:0] DEBUG_PINS = 8'h00,
	parameter logic [7:0] TRIG_PINS = 8'h00
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	input wire logic [7:0] periph_out,
	input wire logic [7:0] periph_oe,
	output logic [7:0] periph_in,
	output logic [7:0] pull_up,
	output logic [7:0] pull_down,
	output logic [7:0] drive_low,
	output logic [7:0] drive_mid,
	output logic [7:0] drive_high,
	output logic [7:0] slew_ctrl,
	output logic [7:0] dig_en,
	output logic irq,
	output logic conv_trigger
);
	localparam logic [7:0] DBG = DEBUG_PINS;

	logic [7:0] data_q, data_d, dir_q, dir_d;
	logic [7:0] is_q, is_d, ibe_q, ibe_d, iev_q, iev_d, im_q, im_d;
	logic [7:0] af_q, af_d, odr_q, odr_d, pur_q, pur_d, pdr_q, pdr_d;
	logic [7:0] dr2_q, dr2_d, dr4_q, dr4_d, dr8_q, dr8_d;
	logic [7:0] slr_q, slr_d, den_q, den_d, cr_q, cr_d;
	logic unlock_q, unlock_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] amask, mis, clr, sw_out;
	logic data_sel;
	logic [7:0] af_keep;

	gpp_cfg_if cfg_bus ();

	assign cfg_bus.sense = is_q;
	assign cfg_bus.both = ibe_q;
	assign cfg_bus.event_hi = iev_q;
	assign cfg_bus.mask = im_q;
	assign cfg_bus.clr = clr;
	assign cfg_bus.pin_in = pin_in;

	gpp_irq_det u_det (
		.clk(clk),
		.rst(rst),
		.cfg(cfg_bus)
	);

	gpp_pad_mux u_mux (
		.alt_sel(af_q),
		.dir(dir_q),
		.data(data_q),
		.odr(odr_q),
		.periph_out(periph_out),
		.periph_oe(periph_oe),
		.pad_out(sw_out),
		.pad_oe(pin_oe)
	);

	// ------------------------------------------------------------
	// Decode and interrupt outputs
	// ------------------------------------------------------------
	// Any address up to the top data word (OFS_DATA_TOP) hits the data alias
	assign data_sel = reg_addr <= gpp_pkg::OFS_DATA_TOP;
	assign amask = reg_addr[gpp_pkg::MASK_HI:gpp_pkg::MASK_LO];
	assign clr = (reg_wr && reg_addr == gpp_pkg::OFS_ICR) ?
		reg_wdata[7:0] : 8'h00;
	assign mis = cfg_bus.raw & cfg_bus.mask;
	// Commit bits count only while unlocked; relock guards again
	assign af_keep = DBG & ~(cr_q & {8{unlock_q}});
	assign irq = |mis;
	assign conv_trigger = |(mis & TRIG_PINS);
	assign pin_out = sw_out;
	assign periph_in = pin_in & den_q;
	assign pull_up = pur_q;
	assign pull_down = pdr_q;
	assign drive_low = dr2_q;
	assign drive_mid = dr4_q;
	assign drive_high = dr8_q;
	assign slew_ctrl = slr_q;
	assign dig_en = den_q;
	assign reg_rdata = rdata_q;

	// ------------------------------------------------------------
	// Register next state
	// ------------------------------------------------------------
	always_comb
	begin
		dir_d = dir_q;
		is_d = is_q;
		ibe_d = ibe_q;
		iev_d = iev_q;
		im_d = im_q;
		af_d = af_q;
		odr_d = odr_q;
		pur_d = pur_q;
		pdr_d = pdr_q;
		dr2_d = dr2_q;
		dr4_d = dr4_q;
		dr8_d = dr8_q;
		slr_d = slr_q;
		den_d = den_q;
		cr_d = cr_q;
		unlock_d = unlock_q;
		// Inputs track the pin; outputs hold software value
		data_d = (data_q & dir_q) | (pin_in & ~dir_q);
		if (reg_wr && data_sel)
			data_d = (data_d & ~(amask & dir_q))
				| (reg_wdata[7:0] & amask & dir_q);
		if (reg_wr)
		begin
			unique case (reg_addr)
				gpp_pkg::OFS_DIR: dir_d = reg_wdata[7:0];
				gpp_pkg::OFS_IS: is_d = reg_wdata[7:0];
				gpp_pkg::OFS_IBE: ibe_d = reg_wdata[7:0];
				gpp_pkg::OFS_IEV: iev_d = reg_wdata[7:0];
				gpp_pkg::OFS_IM: im_d = reg_wdata[7:0];
				// Protected bits change only while committable
				gpp_pkg::OFS_AFSEL: af_d = (af_q & af_keep)
					| (reg_wdata[7:0] & ~af_keep);
				gpp_pkg::OFS_ODR: odr_d = reg_wdata[7:0];
				gpp_pkg::OFS_PUR: pur_d = reg_wdata[7:0];
				gpp_pkg::OFS_PDR: pdr_d = reg_wdata[7:0];
				gpp_pkg::OFS_DR2: dr2_d = reg_wdata[7:0];
				gpp_pkg::OFS_DR4: dr4_d = reg_wdata[7:0];
				gpp_pkg::OFS_DR8: dr8_d = reg_wdata[7:0];
				gpp_pkg::OFS_SLR: slr_d = reg_wdata[7:0];
				gpp_pkg::OFS_DEN: den_d = reg_wdata[7:0];
				gpp_pkg::OFS_LOCK:
					unlock_d = reg_wdata == gpp_pkg::LOCK_KEY;
				gpp_pkg::OFS_CR:
					if (unlock_q)
						cr_d = (cr_q & ~DBG) | (reg_wdata[7:0] & DBG);
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read mux, registered
	// ------------------------------------------------------------
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (reg_rd)
		begin
			if (data_sel)
				rdata_d[7:0] = data_q & amask;
			else if (reg_addr >= gpp_pkg::OFS_PID0
				&& reg_addr <= gpp_pkg::OFS_CID3)
				rdata_d[7:0] = gpp_pkg::ID_BYTE;
			else
			begin
				unique case (reg_addr)
					gpp_pkg::OFS_DIR: rdata_d[7:0] = dir_q;
					gpp_pkg::OFS_IS: rdata_d[7:0] = is_q;
					gpp_pkg::OFS_IBE: rdata_d[7:0] = ibe_q;
					gpp_pkg::OFS_IEV: rdata_d[7:0] = iev_q;
					gpp_pkg::OFS_IM: rdata_d[7:0] = im_q;
					gpp_pkg::OFS_RIS: rdata_d[7:0] = cfg_bus.raw;
					gpp_pkg::OFS_MIS: rdata_d[7:0] = mis;
					gpp_pkg::OFS_AFSEL: rdata_d[7:0] = af_q;
					gpp_pkg::OFS_ODR: rdata_d[7:0] = odr_q;
					gpp_pkg::OFS_PUR: rdata_d[7:0] = pur_q;
					gpp_pkg::OFS_PDR: rdata_d[7:0] = pdr_q;
					gpp_pkg::OFS_DR2: rdata_d[7:0] = dr2_q;
					gpp_pkg::OFS_DR4: rdata_d[7:0] = dr4_q;
					gpp_pkg::OFS_DR8: rdata_d[7:0] = dr8_q;
					gpp_pkg::OFS_SLR: rdata_d[7:0] = slr_q;
					gpp_pkg::OFS_DEN: rdata_d[7:0] = den_q;
					gpp_pkg::OFS_LOCK: rdata_d[0] = ~unlock_q;
					gpp_pkg::OFS_CR: rdata_d[7:0] = cr_q;
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			// Ordinary pins tri-state, debug pins keep debug role
			data_q <= gpp_pkg::RST_ZERO;
			dir_q <= gpp_pkg::RST_ZERO;
			is_q <= gpp_pkg::RST_ZERO;
			ibe_q <= gpp_pkg::RST_ZERO;
			iev_q <= gpp_pkg::RST_ZERO;
			im_q <= gpp_pkg::RST_ZERO;
			af_q <= DBG;
			den_q <= DBG;
			pur_q <= DBG;
			pdr_q <= gpp_pkg::RST_ZERO;
			odr_q <= gpp_pkg::RST_ZERO;
			dr2_q <= gpp_pkg::RST_DR2;
			dr4_q <= gpp_pkg::RST_ZERO;
			dr8_q <= gpp_pkg::RST_ZERO;
			slr_q <= gpp_pkg::RST_ZERO;
			cr_q <= gpp_pkg::RST_CR & ~DBG;
			unlock_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			data_q <= data_d;
			dir_q <= dir_d;
			is_q <= is_d;
			ibe_q <= ibe_d;
			iev_q <= iev_d;
			im_q <= im_d;
			af_q <= af_d;
			den_q <= den_d;
			pur_q <= pur_d;
			pdr_q <= pdr_d;
			odr_q <= odr_d;
			dr2_q <= dr2_d;
			dr4_q <= dr4_d;
			dr8_q <= dr8_d;
			slr_q <= slr_d;
			cr_q <= cr_d;
			unlock_q <= unlock_d;
			rdata_q <= rdata_d;
		end
	end
endmodule : gpp_port

// ===== gpp_pin_model.sv
// Purpose: Board side of the eight port pins
// Assumes: Pull resistors are weak against the port driver, but override the board source
// Notes: Pull-up wins over pull-down when both are set
`timescale 1ns/100ps
module gpp_pin_model (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pull_up,
	input wire logic [7:0] pull_down,
	input wire logic [7:0] ext_level,
	output logic [7:0] pin_level
);
	// Undriven pin: pull level, else the board source
	assign pin_level = (pin_oe & pin_out)
		| (~pin_oe & (pull_up | (~pull_down & ext_level)));
endmodule : gpp_pin_model

// ===== gpp_port_monitor.sv
// Purpose: Port-level checks for the general-purpose port
// Assumes: No open drain or peripheral on pins 6:1 at direction writes
// Notes: Bound into every port instance
`timescale 1ns/100ps
module gpp_port_mon (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_oe,
	input wire logic irq,
	input wire logic conv_trigger
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_read_mask: assert property (
		reg_rd && reg_addr <= 12'h3fc |=>
		(reg_rdata[7:0] & ~$past(reg_addr[9:2])) == 8'h00)
		else $error("masked read returned an unmasked bit");
	chk_read_upper: assert property (
		reg_rd && reg_addr <= 12'h3fc |=> reg_rdata[31:8] == 24'h0)
		else $error("data alias read upper bits not zero");
	chk_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data present without a read");
	chk_trig_irq: assert property (
		conv_trigger |-> irq)
		else $error("converter trigger without port interrupt");
	chk_dir_oe: assert property (
		reg_wr && reg_addr == 12'h400 |=>
		pin_oe[6:1] == $past(reg_wdata[6:1]))
		else $error("direction write not seen on output enables");
	chk_rst_tristate: assert property (
		$fell(rst) |-> pin_oe[6:0] == 7'h00)
		else $error("ordinary pin driven after reset");
	chk_input_read: assert property (
		reg_rd && reg_addr == 12'h3fc && !pin_oe[2] && $stable(pin_in[2])
		|=> reg_rdata[2] == $past(pin_in[2]))
		else $error("input pin level not captured");
	chk_trig_mask: assert property (
		reg_wr && reg_addr == 12'h410 && !reg_wdata[4] |=> !conv_trigger)
		else $error("masked pin still triggers converter");
	chk_trig_only: assert property (
		reg_wr && reg_addr == 12'h410 && reg_wdata[7:0] == 8'h10 |=>
		conv_trigger == irq)
		else $error("converter trigger differs from lone pin interrupt");
endmodule : gpp_port_mon
bind gpp_port gpp_port_mon u_mon (.clk(clk), .rst(rst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .pin_in(pin_in), .pin_oe(pin_oe), .irq(irq),
	.conv_trigger(conv_trigger));

// ===== gpp_port_bench.sv
// Purpose: Self-checking bench for one port built as port B
// Assumes: Strobes driven 1 ns after the rising edge
// Notes: Expectations worked out by hand from the offsets
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end
module gpp_port_bench;
	typedef struct {logic [11:0] wa; logic [7:0] wd;
		logic [11:0] ra; logic [7:0] rv;} gpp_row_t;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [7:0] pin_level, pin_out, pin_oe, pull_up, pull_down;
	logic [7:0] ext_level = 8'h00, periph_out = 8'h00, periph_oe = 8'h00;
	logic irq, conv_trigger;
	logic [7:0] periph_in, drive_low, drive_mid;
	logic [7:0] drive_high, slew_ctrl, dig_en;
	int err_count = 0, n_checks = 0;
	logic [5:0] md [6] = '{6'b001011, 6'b000101, 6'b010101, 6'b101011,
		6'b100101, 6'b001100};
	gpp_row_t rows [15] = '{
		'{12'h400, 8'hff, 12'h400, 8'hff},
		'{12'h3fc, 8'h00, 12'h3fc, 8'h00},
		'{12'h098, 8'heb, 12'h3fc, 8'h22},
		'{12'h600, 8'hff, 12'h0c4, 8'h20},
		'{12'h600, 8'hff, 12'h600, 8'h00},
		'{12'h600, 8'hff, 12'h500, 8'hff},
		'{12'h600, 8'hff, 12'h420, 8'h80},
		'{12'h600, 8'hff, 12'h510, 8'h80},
		'{12'h600, 8'hff, 12'h51c, 8'h80},
		'{12'h600, 8'hff, 12'h514, 8'h00},
		'{12'h600, 8'hff, 12'hfd0, gpp_pkg::ID_BYTE},
		'{12'h504, 8'h3c, 12'h504, 8'h3c},
		'{12'h024, 8'h0f, 12'h3fc, 8'h2b},
		'{12'h508, 8'h40, 12'h508, 8'h40},
		'{12'h518, 8'h81, 12'h518, 8'h81}};
	gpp_port #(.DEBUG_PINS(8'h80), .TRIG_PINS(8'h10)) dut (.clk(clk),
		.rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_level),
		.pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
		.periph_oe(periph_oe), .periph_in(periph_in), .pull_up(pull_up),
		.pull_down(pull_down), .drive_low(drive_low),
		.drive_mid(drive_mid), .drive_high(drive_high),
		.slew_ctrl(slew_ctrl), .dig_en(dig_en), .irq(irq),
		.conv_trigger(conv_trigger));
	gpp_pin_model board (.pin_out(pin_out), .pin_oe(pin_oe),
		.pull_up(pull_up), .pull_down(pull_down), .ext_level(ext_level),
		.pin_level(pin_level));
	initial
	begin
		forever #5 clk = ~clk;
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		`CHK(reg_rdata, {24'h0, v})
	endtask : rd
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	initial
	begin
		#100000 err_count++;
		final_report();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		foreach (rows[i])
		begin
			wr(rows[i].wa, {24'h0, rows[i].wd});
			rd(rows[i].ra, rows[i].rv);
		end
		`CHK(pin_oe[6:0], 7'h7f)
		`CHK(pin_out[6:0], 7'h2b)
		`CHK(drive_low, 8'hff)
		`CHK(drive_mid, 8'h3c)
		`CHK(drive_high, 8'h40)
		`CHK(slew_ctrl, 8'h81)
		`CHK(dig_en, 8'h80)
		`CHK(pull_up, 8'h80)
		`CHK(pull_down, 8'h00)
		wr(12'h400, 32'h0);
		ext_level = 8'h25;
		settle();
		rd(12'h3fc, 8'ha5);
		// Mask first: config writes may fake an event
		for (int m = 0; m < 6; m++)
		begin
			wr(12'h410, 32'h0);
			wr(12'h404, {27'h0, md[m][5], 4'h0});
			wr(12'h408, {27'h0, md[m][4], 4'h0});
			wr(12'h40c, {27'h0, md[m][3], 4'h0});
			ext_level[4] = md[m][2];
			settle();
			wr(12'h41c, 32'hff);
			wr(12'h410, 32'h10);
			ext_level[4] = md[m][1];
			settle();
			`CHK(irq, md[m][0])
			`CHK(conv_trigger, md[m][0])
		end
		ext_level[4] = 1'b1;
		settle();
		ext_level[4] = 1'b0;
		settle();
		`CHK(irq, 1'b1)
		wr(12'h41c, 32'hef);
		`CHK(irq, 1'b1)
		wr(12'h41c, 32'h10);
		`CHK(irq, 1'b0)
		wr(12'h410, 32'h0);
		ext_level[4] = 1'b1;
		settle();
		`CHK(irq, 1'b0)
		rd(12'h414, 8'h10);
		rd(12'h418, 8'h00);
		wr(12'h420, 32'h0);
		rd(12'h420, 8'h80);
		wr(12'h520, gpp_pkg::LOCK_KEY);
		rd(12'h520, 8'h00);
		wr(12'h524, 32'hff);
		wr(12'h420, 32'h01);
		rd(12'h420, 8'h01);
		periph_oe = 8'h01;
		periph_out = 8'h01;
		#1 `CHK(pin_oe[0], 1'b1)
		// Relocked: commit bits alone must not open the debug pin
		wr(12'h520, 32'h0);
		wr(12'h420, 32'h81);
		rd(12'h420, 8'h01);
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		rd(12'h420, 8'h80);
		rd(12'h400, 8'h00);
		rd(12'h520, 8'h01);
		`CHK(periph_in, 8'h80)
		// Open drain: low drives, high releases
		wr(12'h400, 32'h02);
		wr(12'h50c, 32'h02);
		`CHK(pin_oe[1], 1'b1)
		wr(12'h008, 32'h02);
		`CHK(pin_oe[1], 1'b0)
		`CHK(pin_out[1], 1'b0)
		final_report();
	end
endmodule : gpp_port_bench
